// ### rtl/eprom_protect.sv
// eprom_protect: code memory with lock levels, encrypted verify,
// signature read and erase, as seen by the core and the programmer
// assumes: programmer requests are one-cycle strobes on clock_i
`timescale 1ns/1ns
`default_nettype none
module eprom_protect
  import eprom_prot_pkg::*;
#(
  parameter int CODE_KB = CODE_KB_DEFAULT
)(
  // clock and reset
  input  wire logic                clock_i,
  input  wire logic                rstn_i,
  // programmer request
  input  wire logic                pgm_req_i,
  input  wire eprom_prot_pkg::cmd_type pgm_cmd_i,
  input  wire logic [ADDR_W-1:0]   pgm_addr_i,
  input  wire logic [7:0]          pgm_data_i,
  // programmer answer
  output logic                     pgm_valid_o,
  output logic                     pgm_refused_o,
  output logic      [7:0]          pgm_data_o,
  output logic                     busy_o,
  // core table reads
  input  wire logic                cpu_rd_i,
  input  wire logic [ADDR_W-1:0]   cpu_addr_i,
  input  wire logic                cpu_pc_external_i,
  output logic                     cpu_valid_o,
  output logic                     cpu_blocked_o,
  output logic      [7:0]          cpu_rdata_o,
  // external access pin and execution gate
  input  wire logic                external_access_select_i,
  output logic                     external_access_select_o,
  output logic                     ext_exec_allowed_o,
  output logic      [1:0]          level_o
);
  import eprom_prot_pkg::*;

  localparam int CODE_BYTES = CODE_KB * 1024;
  localparam int CODE_AW    = $clog2(CODE_BYTES);

  // **************************************************
  // elaboration check
  // **************************************************
  if (CODE_KB != 16 && CODE_KB != 32 && CODE_KB != 64) begin : g_bad_size
    $error("CODE_KB must be 16, 32 or 64");
  end

  // **************************************************
  // storage and state
  // **************************************************
  logic [7:0]         code_mem [CODE_BYTES]; // code array, no reset
  logic [LOCK_W-1:0]  lock_q;                // lock bits, zero = programmed
  state_type          state_q;               // idle or erasing
  logic [CODE_AW-1:0] wipe_q;                // erase walk address
  logic               ea_caught_q;           // pin latched since reset
  logic               ea_latch_q;            // pin value at reset release

  // **************************************************
  // decoded request and level
  // **************************************************
  logic [CODE_AW-1:0]   pgm_idx;    // programmer address inside array
  logic [CODE_AW-1:0]   cpu_idx;    // core address inside array
  logic [7:0]           code_pgm;   // addressed code byte, programmer
  logic [7:0]           code_cpu;   // addressed code byte, core
  logic [7:0]           scrambled;  // encrypted verify byte
  logic                 key_blank;  // key array untouched
  logic [1:0]           level;      // current security level
  logic                 tbl_block;  // external table reads blocked
  logic                 ver_off;    // verify disabled
  logic                 exec_off;   // external execution blocked
  logic                 idle;       // sequencer can take a request
  logic                 take;       // request accepted this cycle
  logic                 wr_code;    // code byte write accepted
  logic                 wr_key;     // key byte write accepted
  logic                 start_wipe; // erase accepted
  logic [7:0]           sig_byte;   // addressed signature byte

  assign pgm_idx    = pgm_addr_i[CODE_AW-1:0];
  assign cpu_idx    = cpu_addr_i[CODE_AW-1:0];
  assign code_pgm   = code_mem[pgm_idx];
  assign code_cpu   = code_mem[cpu_idx];
  assign idle       = (state_q == ST_IDLE);
  assign take       = pgm_req_i && idle;
  assign wr_code    = take && (pgm_cmd_i == CMD_WRITE_CODE) && !tbl_block;
  assign wr_key     = take && (pgm_cmd_i == CMD_WRITE_KEY) && !tbl_block;
  assign start_wipe = take && (pgm_cmd_i == CMD_ERASE);

  // level from lock bits
  lock_level_decode u_level (
    .lock_bits_i    (lock_q),
    .level_o        (level),
    .table_block_o  (tbl_block),
    .verify_off_o   (ver_off),
    .ext_exec_off_o (exec_off)
  );

  // key array and scrambler
  key_array u_key (
    .clock_i       (clock_i),
    .rstn_i        (rstn_i),
    .erase_i       (start_wipe),
    .wr_i          (wr_key),
    .idx_i         (pgm_addr_i[KEY_IDX_W-1:0]),
    .data_i        (pgm_data_i),
    .code_byte_i   (code_pgm),
    .verify_byte_o (scrambled),
    .blank_o       (key_blank)
  );

  // signature lookup, fixed and never written
  always_comb begin
    case (pgm_addr_i)
      SIG_ADDR_0: sig_byte = SIG_VAL_0;
      SIG_ADDR_1: sig_byte = SIG_VAL_1;
      SIG_ADDR_2: sig_byte = SIG_VAL_2;
      SIG_ADDR_3: sig_byte = SIG_VAL_3;
      default:    sig_byte = BLANK_BYTE;
    endcase
  end

  // **************************************************
  // code array: programming clears bits, erase walks to ones
  // **************************************************
  always_ff @(posedge clock_i) begin
    if (state_q == ST_ERASE) begin
      code_mem[wipe_q] <= BLANK_BYTE;
    end else if (wr_code) begin
      code_mem[pgm_idx] <= code_pgm & pgm_data_i;
    end
  end

  // **************************************************
  // erase sequencer
  // **************************************************
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
      wipe_q  <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          wipe_q <= '0;
          if (start_wipe) state_q <= ST_ERASE;
        end
        ST_ERASE: begin
          wipe_q <= wipe_q + 1'b1;
          if (wipe_q == CODE_AW'(CODE_BYTES - 1)) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // **************************************************
  // lock bits: programming allowed at any level while idle, only adds locks
  // **************************************************
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_q <= LOCK_BLANK;
    end else if (start_wipe) begin
      lock_q <= LOCK_BLANK;
    end else if (take && pgm_cmd_i == CMD_WRITE_LOCK) begin
      lock_q <= lock_q & pgm_data_i[LOCK_W-1:0];
    end
  end

  // **************************************************
  // programmer answers, one cycle after the request
  // **************************************************
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pgm_valid_o   <= 1'b0;
      pgm_refused_o <= 1'b0;
      pgm_data_o    <= ZERO_BYTE;
    end else begin
      pgm_valid_o   <= 1'b0;
      pgm_refused_o <= 1'b0;
      if (pgm_req_i && !idle) begin
        pgm_refused_o <= 1'b1; // busy erasing
      end else if (take) begin
        case (pgm_cmd_i)
          CMD_VERIFY: begin
            if (ver_off) begin
              pgm_refused_o <= 1'b1;
              pgm_data_o    <= ZERO_BYTE;
            end else begin
              pgm_valid_o <= 1'b1;
              pgm_data_o  <= scrambled;
            end
          end
          CMD_READ_SIG: begin
            pgm_valid_o <= 1'b1;
            pgm_data_o  <= sig_byte;
          end
          CMD_WRITE_CODE, CMD_WRITE_KEY: begin
            pgm_valid_o   <= !tbl_block;
            pgm_refused_o <= tbl_block;
          end
          CMD_WRITE_LOCK, CMD_ERASE: pgm_valid_o <= 1'b1;
          default: pgm_refused_o <= 1'b1;
        endcase
      end
    end
  end

  // busy flag registered so it matches the sequencer state cycle for cycle
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= start_wipe || (state_q == ST_ERASE && wipe_q != CODE_AW'(CODE_BYTES - 1));
    end
  end

  // **************************************************
  // core table reads: plain data unless blocked
  // **************************************************
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cpu_valid_o   <= 1'b0;
      cpu_blocked_o <= 1'b0;
      cpu_rdata_o   <= ZERO_BYTE;
    end else begin
      cpu_valid_o   <= cpu_rd_i;
      cpu_blocked_o <= cpu_rd_i && cpu_pc_external_i && tbl_block;
      if (cpu_rd_i) begin
        cpu_rdata_o <= (cpu_pc_external_i && tbl_block) ? ZERO_BYTE : code_cpu;
      end
    end
  end

  // **************************************************
  // external access pin: latched at reset release when locked
  // **************************************************
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ea_caught_q <= 1'b0;
      ea_latch_q  <= 1'b0;
    end else if (!ea_caught_q) begin
      ea_caught_q <= 1'b1;
      ea_latch_q  <= external_access_select_i;
    end
  end

  // pin view, execution gate and level for the core
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      external_access_select_o <= 1'b0;
      ext_exec_allowed_o       <= 1'b0;
      level_o                  <= LEVEL_1;
    end else begin
      external_access_select_o <= (tbl_block && ea_caught_q) ? ea_latch_q
                                                             : external_access_select_i;
      ext_exec_allowed_o       <= !exec_off;
      level_o                  <= level;
    end
  end

  // **************************************************
  // checks
  // **************************************************
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  // expected byte rebuilt from the stored key, not from the scrambler output
  chk_verify_xnor: assert property (
    take && pgm_cmd_i == CMD_VERIFY && !ver_off |=>
      pgm_valid_o && pgm_data_o ==
      ~($past(code_pgm) ^ $past(u_key.key_q[pgm_addr_i[KEY_IDX_W-1:0]])))
    else $error("verify byte not scrambled code");
  chk_blank_key: assert property (
    take && pgm_cmd_i == CMD_VERIFY && !ver_off && key_blank |=>
      pgm_data_o == $past(code_pgm))
    else $error("blank key changed verify byte");
  chk_no_program: assert property (
    take && pgm_cmd_i == CMD_WRITE_CODE && level != LEVEL_1 |=>
      pgm_refused_o && !pgm_valid_o)
    else $error("code write accepted while locked");
  chk_table_block: assert property (
    cpu_rd_i && cpu_pc_external_i && level != LEVEL_1 |=>
      cpu_blocked_o && cpu_rdata_o == ZERO_BYTE)
    else $error("external table read not blocked");
  chk_plain_read: assert property (
    cpu_rd_i && level == LEVEL_1 |=> !cpu_blocked_o && cpu_rdata_o == $past(code_cpu))
    else $error("unlocked table read not plain");
  chk_verify_off: assert property (
    take && pgm_cmd_i == CMD_VERIFY && level >= LEVEL_3 |=>
      pgm_refused_o && pgm_data_o == ZERO_BYTE)
    else $error("verify answered while disabled");
  chk_exec_gate: assert property (
    level == LEVEL_4 ##1 level == LEVEL_4 |-> !ext_exec_allowed_o)
    else $error("external execution allowed at level 4");
  chk_most_strict: assert property (
    !lock_q[LOCK_THIRD_POS] |-> level == LEVEL_4 && tbl_block && ver_off)
    else $error("lock levels do not accumulate");
  chk_erase_locks: assert property (
    start_wipe |=> lock_q == LOCK_BLANK && busy_o && state_q == ST_ERASE)
    else $error("erase did not clear locks");
  chk_signature: assert property (
    take && pgm_cmd_i == CMD_READ_SIG && pgm_addr_i == SIG_ADDR_2 |=>
      pgm_valid_o && pgm_data_o == SIG_VAL_2)
    else $error("signature byte wrong");

  cov_verify: cover property (take && pgm_cmd_i == CMD_VERIFY ##1 pgm_valid_o);
  cov_blocked: cover property (cpu_blocked_o);
  cov_erase: cover property (start_wipe ##1 busy_o);
endmodule : eprom_protect
`default_nettype wire

// ### inc/eprom_prot_pkg.sv
// eprom_prot_pkg: constants and types of the code memory protection block
// assumes: one clock, programmer and core strobes synchronous to clock_i
package eprom_prot_pkg;
  // **************************************************
  // sizes
  // **************************************************
  localparam int ADDR_W          = 16;
  localparam int CODE_KB_DEFAULT = 64;
  localparam int KEY_BYTES       = 64;
  localparam int KEY_IDX_W       = 6;
  localparam int LOCK_W          = 3;
  // **************************************************
  // values
  // **************************************************
  localparam logic [7:0]        BLANK_BYTE = 8'hFF;
  localparam logic [7:0]        ZERO_BYTE  = 8'h00;
  localparam logic [LOCK_W-1:0] LOCK_BLANK = 3'h7;
  // lock bit positions, a programmed bit reads zero
  localparam int LOCK_FIRST_POS  = 0;
  localparam int LOCK_SECOND_POS = 1;
  localparam int LOCK_THIRD_POS  = 2;
  // security levels 1..4 as 0..3
  localparam logic [1:0] LEVEL_1 = 2'h0;
  localparam logic [1:0] LEVEL_2 = 2'h1;
  localparam logic [1:0] LEVEL_3 = 2'h2;
  localparam logic [1:0] LEVEL_4 = 2'h3;
  // **************************************************
  // signature locations and contents (contents arbitrary)
  // **************************************************
  localparam logic [ADDR_W-1:0] SIG_ADDR_0 = 16'h0030;
  localparam logic [ADDR_W-1:0] SIG_ADDR_1 = 16'h0031;
  localparam logic [ADDR_W-1:0] SIG_ADDR_2 = 16'h0060;
  localparam logic [ADDR_W-1:0] SIG_ADDR_3 = 16'h0061;
  localparam logic [7:0]        SIG_VAL_0  = 8'hA1;
  localparam logic [7:0]        SIG_VAL_1  = 8'hB2;
  localparam logic [7:0]        SIG_VAL_2  = 8'hC3;
  localparam logic [7:0]        SIG_VAL_3  = 8'hD4;
  // **************************************************
  // programmer commands and sequencer states
  // **************************************************
  typedef enum logic [2:0] {
    CMD_WRITE_CODE = 3'h0,
    CMD_WRITE_KEY  = 3'h1,
    CMD_WRITE_LOCK = 3'h2,
    CMD_VERIFY     = 3'h3,
    CMD_READ_SIG   = 3'h4,
    CMD_ERASE      = 3'h5
  } cmd_type;
  typedef enum logic [0:0] {
    ST_IDLE  = 1'h0,
    ST_ERASE = 1'h1
  } state_type;
endpackage : eprom_prot_pkg

// ### rtl/key_array.sv
// key_array: the 64-byte encryption array and the verify scrambler
// assumes: writes and erase come from the protection top, one per cycle
`timescale 1ns/1ns
`default_nettype none
module key_array
  import eprom_prot_pkg::*;
(
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rstn_i,
  // programming side
  input  wire logic                 erase_i,
  input  wire logic                 wr_i,
  input  wire logic [KEY_IDX_W-1:0] idx_i,
  input  wire logic [7:0]           data_i,
  // verify side: only the scrambled byte and the blank flag leave
  input  wire logic [7:0]           code_byte_i,
  output logic      [7:0]           verify_byte_o,
  output logic                      blank_o
);
  import eprom_prot_pkg::*;

  logic [7:0] key_q [KEY_BYTES]; // key bytes, blank is all ones
  logic       all_ones;          // every key byte still blank

  // **************************************************
  // storage: writes only clear bits, erase restores ones
  // **************************************************
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < KEY_BYTES; i++) key_q[i] <= BLANK_BYTE;
    end else if (erase_i) begin
      for (int i = 0; i < KEY_BYTES; i++) key_q[i] <= BLANK_BYTE;
    end else if (wr_i) begin
      key_q[idx_i] <= key_q[idx_i] & data_i;
    end
  end

  // **************************************************
  // scrambler: code byte XNOR key byte, so a blank code byte returns the key byte itself
  // **************************************************
  always_comb begin
    verify_byte_o = ~(code_byte_i ^ key_q[idx_i]);
    all_ones = 1'b1;
    for (int i = 0; i < KEY_BYTES; i++) all_ones = all_ones & (&key_q[i]);
    blank_o = all_ones;
  end
endmodule : key_array
`default_nettype wire

// ### rtl/lock_level_decode.sv
// lock_level_decode: folds the three lock bits into one security level
// assumes: lock bits read zero when programmed
`timescale 1ns/1ns
`default_nettype none
module lock_level_decode
  import eprom_prot_pkg::*;
(
  // lock bits
  input  wire logic [LOCK_W-1:0] lock_bits_i,
  // resulting level and restrictions
  output logic      [1:0]        level_o,
  output logic                   table_block_o,
  output logic                   verify_off_o,
  output logic                   ext_exec_off_o
);
  import eprom_prot_pkg::*;

  // **************************************************
  // most restrictive programmed bit decides
  // **************************************************
  always_comb begin
    if (!lock_bits_i[LOCK_THIRD_POS]) begin
      level_o = LEVEL_4;
    end else if (!lock_bits_i[LOCK_SECOND_POS]) begin
      level_o = LEVEL_3;
    end else if (!lock_bits_i[LOCK_FIRST_POS]) begin
      level_o = LEVEL_2;
    end else begin
      level_o = LEVEL_1;
    end
    table_block_o  = (level_o >= LEVEL_2);
    verify_off_o   = (level_o >= LEVEL_3);
    ext_exec_off_o = (level_o == LEVEL_4);
  end
endmodule : lock_level_decode
`default_nettype wire

// ### tb/programmer_model.sv
// programmer_model: behavioural external programmer for the protection block
// assumes: requests launched on the falling edge, answers registered on clock_i
`timescale 1ns/1ns
`default_nettype none
module programmer_model
  import eprom_prot_pkg::*;
(
  // clock
  input  wire logic                    clock_i,
  // request lines
  output logic                         req_o,
  output eprom_prot_pkg::cmd_type      cmd_o,
  output logic      [ADDR_W-1:0]       addr_o,
  output logic      [7:0]              data_o,
  // answer lines
  input  wire logic                    valid_i,
  input  wire logic                    refused_i,
  input  wire logic [7:0]              data_i,
  input  wire logic                    busy_i
);
  import eprom_prot_pkg::*;
  // idle lines at time zero
  initial begin
    req_o  = 1'b0;
    cmd_o  = CMD_VERIFY;
    addr_o = 16'h0000;
    data_o = 8'h00;
  end
  // one strobe; the registered answer is taken at the next falling edge
  task automatic send(input cmd_type cmd, input logic [ADDR_W-1:0] addr,
                      input logic [7:0] wdata, output logic ok, output logic no,
                      output logic [7:0] rdata);
    @(negedge clock_i);
    req_o  = 1'b1;
    cmd_o  = cmd;
    addr_o = addr;
    data_o = wdata;
    @(negedge clock_i);
    ok     = valid_i;
    no     = refused_i;
    rdata  = data_i;
    req_o  = 1'b0;
    // released lines must not keep the last value
    addr_o = ~addr;
    data_o = ~wdata;
  endtask : send
  // unused code gets a changing non-blank pattern so verify never shows the key
  task automatic fill(input logic [ADDR_W-1:0] base, input int n);
    logic       o;
    logic       r;
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      send(CMD_WRITE_CODE, base + ADDR_W'(i), 8'h5A ^ 8'(i), o, r, d);
    end
  endtask : fill
  // bounded wait for the erase walk to finish
  task automatic wait_idle(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 20000; i++) begin
      @(negedge clock_i);
      if (busy_i === 1'b0) begin
        ok = 1'b1;
        break;
      end
    end
  endtask : wait_idle
endmodule : programmer_model
`default_nettype wire

// ### tb/eprom_lock_and_verify_protection_bench.sv
// eprom_lock_and_verify_protection_bench: self-checking bench of eprom_protect
// assumes: programmer_model drives the programmer side; bench drives core and pin
`timescale 1ns/1ns
`default_nettype none
module eprom_lock_and_verify_protection_bench;
  import eprom_prot_pkg::*;
  // **************************************************
  // signals
  // **************************************************
  localparam int CODE_KB = 16;  // smallest variant keeps the erase walk short
  logic              clock_i;
  logic              rstn_i;
  logic              pgm_req_i;
  cmd_type           pgm_cmd_i;
  logic [ADDR_W-1:0] pgm_addr_i;
  logic [7:0]        pgm_data_i;
  logic              pgm_valid_o;
  logic              pgm_refused_o;
  logic [7:0]        pgm_data_o;
  logic              busy_o;
  logic              cpu_rd_i;
  logic [ADDR_W-1:0] cpu_addr_i;
  logic              cpu_pc_external_i;
  logic              cpu_valid_o;
  logic              cpu_blocked_o;
  logic [7:0]        cpu_rdata_o;
  logic              external_access_select_i;
  logic              external_access_select_o;
  logic              ext_exec_allowed_o;
  logic [1:0]        level_o;
  int                mismatches;
  int                n_checks;
  // **************************************************
  // instances
  // **************************************************
  eprom_protect #(.CODE_KB(CODE_KB)) i_dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .pgm_req_i(pgm_req_i), .pgm_cmd_i(pgm_cmd_i),
    .pgm_addr_i(pgm_addr_i), .pgm_data_i(pgm_data_i), .pgm_valid_o(pgm_valid_o),
    .pgm_refused_o(pgm_refused_o), .pgm_data_o(pgm_data_o), .busy_o(busy_o),
    .cpu_rd_i(cpu_rd_i), .cpu_addr_i(cpu_addr_i), .cpu_pc_external_i(cpu_pc_external_i),
    .cpu_valid_o(cpu_valid_o), .cpu_blocked_o(cpu_blocked_o), .cpu_rdata_o(cpu_rdata_o),
    .external_access_select_i(external_access_select_i),
    .external_access_select_o(external_access_select_o),
    .ext_exec_allowed_o(ext_exec_allowed_o), .level_o(level_o));
  programmer_model i_prog (
    .clock_i(clock_i), .req_o(pgm_req_i), .cmd_o(pgm_cmd_i), .addr_o(pgm_addr_i),
    .data_o(pgm_data_i), .valid_i(pgm_valid_o), .refused_i(pgm_refused_o),
    .data_i(pgm_data_o), .busy_i(busy_o));
  // **************************************************
  // clock and watchdog
  // **************************************************
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  initial begin
    repeat (100000) @(posedge clock_i);
    mismatches++;
    report_and_stop();
  end
  // **************************************************
  // shared tasks
  // **************************************************
  task automatic report_and_stop();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // programmer request; exp_vr is {valid, refused}
  task automatic op(input cmd_type c, input logic [15:0] a, input logic [7:0] wd,
                    input logic [1:0] exp_vr, input logic [7:0] exp_d);
    logic       v;
    logic       r;
    logic [7:0] d;
    i_prog.send(c, a, wd, v, r, d);
    chk({6'h00, v, r}, {6'h00, exp_vr}, "answer kind");
    if (c == CMD_VERIFY || c == CMD_READ_SIG) begin
      chk(d, exp_d, "answer byte");
    end
  endtask : op
  // core table read, answer taken one cycle after the strobe
  task automatic core_rd(input logic [15:0] a, input logic ext, input logic exp_blk,
                         input logic [7:0] exp_d);
    @(negedge clock_i);
    cpu_rd_i          = 1'b1;
    cpu_addr_i        = a;
    cpu_pc_external_i = ext;
    @(negedge clock_i);
    chk({7'h00, cpu_valid_o}, 8'h01, "core valid");
    chk({7'h00, cpu_blocked_o}, {7'h00, exp_blk}, "core blocked");
    chk(cpu_rdata_o, exp_d, "core data");
    cpu_rd_i   = 1'b0;
    cpu_addr_i = ~a;
  endtask : core_rd
  // erase and wait for the walk to end
  task automatic erase_all();
    logic ok;
    op(CMD_ERASE, 16'h0000, 8'h00, 2'b10, 8'h00);
    op(CMD_WRITE_CODE, 16'h0105, 8'h00, 2'b01, 8'h00);
    i_prog.wait_idle(ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t erase never finished", $time);
      report_and_stop();
    end
  endtask : erase_all
  // lock state after a lock write has settled
  task automatic chk_level(input logic [1:0] lvl, input logic exec);
    repeat (2) @(negedge clock_i);
    chk({6'h00, level_o}, {6'h00, lvl}, "level");
    chk({7'h00, ext_exec_allowed_o}, {7'h00, exec}, "external execution");
  endtask : chk_level
  // **************************************************
  // scenarios
  // **************************************************
  task automatic t_encrypt();
    erase_all();
    op(CMD_VERIFY, 16'h0105, 8'h00, 2'b10, 8'hFF);
    op(CMD_WRITE_CODE, 16'h0105, 8'h3C, 2'b10, 8'h00);
    op(CMD_WRITE_KEY, 16'h0005, 8'hA5, 2'b10, 8'h00);
    op(CMD_VERIFY, 16'h0105, 8'h00, 2'b10, ~(8'h3C ^ 8'hA5));
    op(CMD_VERIFY, 16'h0145, 8'h00, 2'b10, 8'hA5);
    op(CMD_VERIFY, 16'h4105, 8'h00, 2'b10, ~(8'h3C ^ 8'hA5));
    i_prog.fill(16'h0200, 4);
    op(CMD_VERIFY, 16'h0201, 8'h00, 2'b10, 8'h5B);
  endtask : t_encrypt
  task automatic t_level1();
    core_rd(16'h0105, 1'b1, 1'b0, 8'h3C);
    external_access_select_i = 1'b0;
    repeat (2) @(negedge clock_i);
    chk({7'h00, external_access_select_o}, 8'h00, "pin follows");
    external_access_select_i = 1'b1;
    chk_level(LEVEL_1, 1'b1);
  endtask : t_level1
  task automatic t_signature();
    logic [15:0] sa [4];
    logic [7:0]  sv [4];
    sa = '{SIG_ADDR_0, SIG_ADDR_1, SIG_ADDR_2, SIG_ADDR_3};
    sv = '{SIG_VAL_0, SIG_VAL_1, SIG_VAL_2, SIG_VAL_3};
    for (int i = 0; i < 4; i++) begin
      op(CMD_READ_SIG, sa[i], 8'h00, 2'b10, sv[i]);
    end
    op(CMD_READ_SIG, 16'h0005, 8'h00, 2'b10, 8'hFF);
    op(CMD_WRITE_CODE, SIG_ADDR_0, 8'h00, 2'b10, 8'h00);
    op(CMD_READ_SIG, SIG_ADDR_0, 8'h00, 2'b10, SIG_VAL_0);
  endtask : t_signature
  task automatic t_level2();
    op(CMD_WRITE_LOCK, 16'h0000, 8'hFE, 2'b10, 8'h00);
    chk_level(LEVEL_2, 1'b1);
    core_rd(16'h0105, 1'b1, 1'b1, 8'h00);
    core_rd(16'h0105, 1'b0, 1'b0, 8'h3C);
    op(CMD_WRITE_CODE, 16'h0300, 8'h11, 2'b01, 8'h00);
    op(CMD_WRITE_KEY, 16'h0006, 8'h11, 2'b01, 8'h00);
    op(CMD_VERIFY, 16'h0105, 8'h00, 2'b10, ~(8'h3C ^ 8'hA5));
    external_access_select_i = 1'b0;
    repeat (2) @(negedge clock_i);
    chk({7'h00, external_access_select_o}, 8'h01, "pin latched");
    external_access_select_i = 1'b1;
  endtask : t_level2
  task automatic t_level34();
    op(CMD_WRITE_LOCK, 16'h0000, 8'hFD, 2'b10, 8'h00);
    chk_level(LEVEL_3, 1'b1);
    op(CMD_VERIFY, 16'h0105, 8'h00, 2'b01, 8'h00);
    core_rd(16'h0105, 1'b1, 1'b1, 8'h00);
    op(CMD_WRITE_LOCK, 16'h0000, 8'hFB, 2'b10, 8'h00);
    chk_level(LEVEL_4, 1'b0);
    op(CMD_VERIFY, 16'h0105, 8'h00, 2'b01, 8'h00);
  endtask : t_level34
  task automatic t_erase_restore();
    erase_all();
    chk_level(LEVEL_1, 1'b1);
    op(CMD_VERIFY, 16'h0105, 8'h00, 2'b10, 8'hFF);
    op(CMD_VERIFY, 16'h0201, 8'h00, 2'b10, 8'hFF);
    core_rd(16'h0105, 1'b1, 1'b0, 8'hFF);
  endtask : t_erase_restore
  // **************************************************
  // main sequence
  // **************************************************
  initial begin
    mismatches               = 0;
    n_checks                 = 0;
    rstn_i                   = 1'b0;
    cpu_rd_i                 = 1'b0;
    cpu_addr_i               = 16'h0000;
    cpu_pc_external_i        = 1'b0;
    external_access_select_i = 1'b1;
    repeat (10) @(negedge clock_i);
    rstn_i = 1'b1;
    chk_level(LEVEL_1, 1'b1);
    t_encrypt();
    t_level1();
    t_signature();
    t_level2();
    t_level34();
    t_erase_restore();
    report_and_stop();
  end
endmodule : eprom_lock_and_verify_protection_bench
`default_nettype wire
